// >>> inc/xip_cache_pkg.sv
// Constants, types and carriers shared by the flash read cache and its storage array
package xip_cache_pkg;

   // Cache geometry: 16KB, 4 ways, 4-word lines, 256 sets
   localparam int WAYS = 4;
   localparam int WAY_W = 2;
   localparam int SETS = 256;
   localparam int SET_W = 8;
   localparam int LINE_WORDS = 4;
   localparam int WORD_W = 2;
   localparam int TAG_W = 11;
   localparam int MEM_AW = 12;
   localparam int MEM_DEPTH = 4096;
   localparam int DATA_W = 32;
   localparam int BYTES = 4;

   // Address field positions
   localparam int WORD_LSB = 2;
   localparam int SET_LSB = 4;
   localparam int TAG_LSB = 12;
   localparam int SPACE_W = 23;
   localparam int FLASH_AW = 24;

   // Bus encodings
   localparam logic [2:0] SIZE_BYTE = 3'h0;
   localparam logic [2:0] SIZE_HALF = 3'h1;
   localparam int TRANS_ACTIVE_BIT = 1;

   // Serial flash read sequence
   localparam logic [7:0] CMD_QUAD_READ = 8'h6B;
   localparam int CMD_ADDR_BITS = 32;
   localparam int DUMMY_CLKS = 8;
   localparam int LINE_NIBBLES = 32;
   localparam int CNT_W = 6;
   localparam int SCK_HALF = 2;
   localparam int HALF_W = 1;
   localparam logic [3:0] OE_SINGLE = 4'h1;
   localparam logic [3:0] OE_NONE = 4'h0;
   localparam logic [2:0] NIB_LAST = 3'h7;

   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DUMMY, ST_DATA, ST_DRAIN, ST_DONE} fill_state_type;

   // Address-phase signals of the system bus
   typedef struct packed {
      logic sel_cache;
      logic sel_sram;
      logic [31:0] addr;
      logic [1:0] trans;
      logic write;
      logic [2:0] size;
   } ahb_req_type;

   // Driven side of the quad serial flash pins
   typedef struct packed {
      logic sck;
      logic cs_n;
      logic [3:0] io_out;
      logic [3:0] io_oe;
   } qspi_out_type;

endpackage : xip_cache_pkg

// >>> hw/xip_cache_ram.sv
// Shared 16KB storage array: cache lines in cached mode, plain SRAM in mirrored mode
`timescale 1ns/1ps
`default_nettype none

module xip_cache_ram #(
   parameter int DW = 32,
   parameter int AW = 12,
   parameter int DEPTH = 4096
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [DW/8-1:0] be,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic re,
   input wire logic rzero,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] q
);

   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      for (int b = 0; b < DW / 8; b++) begin
         if (we && be[b]) begin
            mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
         end
      end
   end

   // Registered read; a write to the same word in the same cycle is passed through
   always_ff @(posedge clk) begin
      if (rzero) begin
         q <= '0;
      end else if (re) begin
         for (int b = 0; b < DW / 8; b++) begin
            q[b*8 +: 8] <= (we && be[b] && waddr == raddr) ? wdata[b*8 +: 8] : mem[raddr][b*8 +: 8];
         end
      end
   end

endmodule : xip_cache_ram

`default_nettype wire

// >>> hw/xip_flash_read_cache.sv
// Read-only 4-way cache executing from quad serial flash, doubling as system SRAM when disabled
//
// Function
// - Four-way set associative, 32-bit reads only; writes never reach the flash.
// - A read hitting a valid line returns its word one cycle later.
// - On a miss the block issues the flash read command and fills over quad lines.
// - Cached mode executes straight from flash through the cache.
// - Mirrored mode disables the cache; its 16KB array serves as ordinary SRAM.
// - Cached mode reserves the 16KB array for cache storage only.
// - Cache storage is the top 16kB of system SRAM, one shared array.
`timescale 1ns/1ps
`default_nettype none

module xip_flash_read_cache #(
   parameter int SCK_HALF_CYCLES = xip_cache_pkg::SCK_HALF
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Mode: high for cached, low for mirrored
   input wire logic cache_en,
   // System bus slave
   input wire xip_cache_pkg::ahb_req_type ahb_req,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Quad serial flash
   output xip_cache_pkg::qspi_out_type qspi_out,
   input wire logic [3:0] qspi_io_in
);

   import xip_cache_pkg::*;

   function automatic logic [BYTES-1:0] byte_enables(input logic [2:0] size, input logic [1:0] a);
      logic [BYTES-1:0] be;
      be = '1;
      if (size == SIZE_BYTE) begin
         be = 4'h1 << a;
      end else if (size == SIZE_HALF) begin
         be = a[1] ? 4'hC : 4'h3;
      end
      return be;
   endfunction : byte_enables

   function automatic logic [DATA_W-1:0] byte_swap(input logic [DATA_W-1:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : byte_swap

   ////////////////////////////////////////////////////////////////////////////
   // State

   fill_state_type state_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   logic [TAG_W-1:0] tag_reg [SETS][WAYS];
   logic [WAYS-1:0] valid_reg [SETS];
   logic [WAY_W-1:0] rr_reg;
   logic [WAY_W-1:0] victim_reg;
   logic [SPACE_W-1:0] miss_addr_reg;
   logic wr_pend_reg;
   logic [MEM_AW-1:0] wr_addr_reg;
   logic [BYTES-1:0] wr_be_reg;
   logic sck_reg;
   logic cs_n_reg;
   logic [3:0] oe_reg;
   logic [CMD_ADDR_BITS-1:0] shift_reg;
   logic [HALF_W-1:0] half_reg;
   logic [CNT_W-1:0] bit_cnt_reg;
   logic [4:0] nib_cnt_reg;
   logic [DATA_W-1:0] word_sr_reg;
   logic [3:0] io_meta_reg;
   logic [3:0] io_sync_reg;
   logic [1:0] sample_dly_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Address-phase decode and tag lookup

   logic req_valid;
   logic cache_rd;
   logic sram_acc;
   logic hit;
   logic [WAY_W-1:0] hit_way;
   logic [WAY_W-1:0] victim;
   logic [SET_W-1:0] req_set;
   logic [TAG_W-1:0] req_tag;

   assign req_valid = (ahb_req.sel_cache || ahb_req.sel_sram) && hready && ahb_req.trans[TRANS_ACTIVE_BIT];
   assign req_set = ahb_req.addr[SET_LSB +: SET_W];
   assign req_tag = ahb_req.addr[TAG_LSB +: TAG_W];
   assign cache_rd = req_valid && ahb_req.sel_cache && !ahb_req.write && cache_en && state_reg == ST_IDLE;
   assign sram_acc = req_valid && ahb_req.sel_sram && !cache_en;

   always_comb begin
      hit = 1'b0;
      hit_way = '0;
      victim = rr_reg;
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (valid_reg[req_set][w] && tag_reg[req_set][w] == req_tag) begin
            hit = 1'b1;
            hit_way = WAY_W'(w);
         end
         if (!valid_reg[req_set][w]) begin
            victim = WAY_W'(w);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared storage array

   logic fill_we;
   logic [DATA_W-1:0] fill_word;
   logic mem_we;
   logic [BYTES-1:0] mem_be;
   logic [MEM_AW-1:0] mem_waddr;
   logic [DATA_W-1:0] mem_wdata;
   logic mem_re;
   logic mem_rzero;
   logic [MEM_AW-1:0] mem_raddr;

   assign fill_word = byte_swap({word_sr_reg[DATA_W-5:0], io_sync_reg});
   assign fill_we = sample_dly_reg[1] && nib_cnt_reg[2:0] == NIB_LAST;
   assign mem_we = fill_we || wr_pend_reg;
   assign mem_be = fill_we ? '1 : wr_be_reg;
   assign mem_waddr = fill_we ? {victim_reg, miss_addr_reg[SET_LSB +: SET_W], nib_cnt_reg[4:3]} : wr_addr_reg;
   assign mem_wdata = fill_we ? fill_word : hwdata;

   always_comb begin
      mem_re = 1'b0;
      mem_raddr = ahb_req.addr[WORD_LSB +: MEM_AW];
      if (state_reg == ST_DONE) begin
         mem_re = 1'b1;
         mem_raddr = {victim_reg, miss_addr_reg[WORD_LSB +: SET_W + WORD_W]};
      end else if (cache_rd && hit) begin
         mem_re = 1'b1;
         mem_raddr = {hit_way, ahb_req.addr[WORD_LSB +: SET_W + WORD_W]};
      end else if (sram_acc && !ahb_req.write) begin
         mem_re = 1'b1;
      end
   end
   assign mem_rzero = req_valid && !mem_re;

   xip_cache_ram #(
      .DW(DATA_W),
      .AW(MEM_AW),
      .DEPTH(MEM_DEPTH)
   ) u_ram (
      .clk(clk_sys),
      .we(mem_we),
      .be(mem_be),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .re(mem_re),
      .rzero(mem_rzero),
      .raddr(mem_raddr),
      .q(hrdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus response

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         hresp_reg <= 1'b0;
         if (cache_rd && !hit) begin
            hreadyout_reg <= 1'b0;
         end else if (state_reg == ST_DONE) begin
            hreadyout_reg <= 1'b1;
         end
      end
   end

   // Mirrored-mode writes land in the data phase
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_be_reg <= '0;
      end else begin
         wr_pend_reg <= sram_acc && ahb_req.write;
         wr_addr_reg <= ahb_req.addr[WORD_LSB +: MEM_AW];
         wr_be_reg <= byte_enables(ahb_req.size, ahb_req.addr[1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tags, valid bits and replacement

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !cache_en) begin
         for (int s = 0; s < SETS; s++) begin
            valid_reg[s] <= '0;
         end
      end else if (state_reg == ST_DONE) begin
         valid_reg[miss_addr_reg[SET_LSB +: SET_W]][victim_reg] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (state_reg == ST_DONE) begin
         tag_reg[miss_addr_reg[SET_LSB +: SET_W]][victim_reg] <= miss_addr_reg[TAG_LSB +: TAG_W];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rr_reg <= '0;
         victim_reg <= '0;
         miss_addr_reg <= '0;
      end else if (cache_rd && !hit) begin
         rr_reg <= rr_reg + 1'b1;
         victim_reg <= victim;
         miss_addr_reg <= ahb_req.addr[SPACE_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial flash line fill

   logic active;
   logic half_wrap;
   logic rise;
   logic fall;

   assign active = state_reg == ST_CMD || state_reg == ST_DUMMY || state_reg == ST_DATA;
   assign half_wrap = active && half_reg == HALF_W'(SCK_HALF_CYCLES - 1);
   assign rise = half_wrap && !sck_reg;
   assign fall = half_wrap && sck_reg;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         io_meta_reg <= '0;
         io_sync_reg <= '0;
         sample_dly_reg <= '0;
      end else begin
         io_meta_reg <= qspi_io_in;
         io_sync_reg <= io_meta_reg;
         sample_dly_reg <= {sample_dly_reg[0], rise && state_reg == ST_DATA};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !active) begin
         half_reg <= '0;
         sck_reg <= 1'b0;
      end else begin
         half_reg <= half_wrap ? '0 : half_reg + 1'b1;
         if (half_wrap) begin
            sck_reg <= !sck_reg;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || (cache_rd && !hit)) begin
         nib_cnt_reg <= '0;
         word_sr_reg <= '0;
      end else if (sample_dly_reg[1]) begin
         nib_cnt_reg <= nib_cnt_reg + 1'b1;
         word_sr_reg <= {word_sr_reg[DATA_W-5:0], io_sync_reg};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         cs_n_reg <= 1'b1;
         oe_reg <= OE_NONE;
         shift_reg <= '0;
         bit_cnt_reg <= '0;
      end else begin
         if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
         end
         case (state_reg)
            ST_IDLE: begin
               if (cache_rd && !hit) begin
                  state_reg <= ST_CMD;
                  cs_n_reg <= 1'b0;
                  oe_reg <= OE_SINGLE;
                  shift_reg <= {CMD_QUAD_READ, 1'b0, ahb_req.addr[SPACE_W-1:SET_LSB], 4'h0};
                  bit_cnt_reg <= '0;
               end
            end
            ST_CMD: begin
               if (fall) begin
                  shift_reg <= shift_reg << 1;
                  if (bit_cnt_reg == CNT_W'(CMD_ADDR_BITS)) begin
                     state_reg <= ST_DUMMY;
                     oe_reg <= OE_NONE;
                     bit_cnt_reg <= '0;
                  end
               end
            end
            ST_DUMMY: begin
               if (fall && bit_cnt_reg == CNT_W'(DUMMY_CLKS)) begin
                  state_reg <= ST_DATA;
                  bit_cnt_reg <= '0;
               end
            end
            ST_DATA: begin
               if (fall && bit_cnt_reg == CNT_W'(LINE_NIBBLES)) begin
                  state_reg <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (sample_dly_reg == '0) begin
                  state_reg <= ST_DONE;
                  cs_n_reg <= 1'b1;
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
               cs_n_reg <= 1'b1;
               oe_reg <= OE_NONE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign qspi_out = '{sck: sck_reg, cs_n: cs_n_reg, io_out: {3'h0, shift_reg[CMD_ADDR_BITS-1]}, io_oe: oe_reg};

endmodule : xip_flash_read_cache

`default_nettype wire

// >>> tb/xip_cache_sva.sv
// Port-level assertions for the flash read cache
`timescale 1ns/1ps
`default_nettype none
module xip_cache_sva #(
   parameter int SCK_HALF_CYCLES = 2
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Mode and bus
   input wire logic cache_en,
   input wire xip_cache_pkg::ahb_req_type ahb_req,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Flash
   input wire xip_cache_pkg::qspi_out_type qspi_out,
   input wire logic [3:0] qspi_io_in
);
   import xip_cache_pkg::*;
   logic taken;
   assign taken = (ahb_req.sel_cache | ahb_req.sel_sram) & hready & ahb_req.trans[1];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   //////////////////////////////////////////////////////////////////
   property p_resp_okay;
      hresp == 1'b0;
   endproperty
   a_resp_okay: assert property (p_resp_okay) else $error("error response seen");
   property p_write_no_flash;
      taken && ahb_req.sel_cache && ahb_req.write |=> hreadyout && qspi_out.cs_n;
   endproperty
   a_write_no_flash: assert property (p_write_no_flash) else $error("write reached flash");
   property p_idle_mirrored;
      !cache_en |-> qspi_out.cs_n;
   endproperty
   a_idle_mirrored: assert property (p_idle_mirrored) else $error("flash used while disabled");
   property p_sram_no_wait;
      taken && ahb_req.sel_sram |=> hreadyout;
   endproperty
   a_sram_no_wait: assert property (p_sram_no_wait) else $error("wait state on sram");
   property p_cached_sram_zero;
      taken && ahb_req.sel_sram && !ahb_req.write && cache_en |=> hrdata == 32'h0000_0000;
   endproperty
   a_cached_sram_zero: assert property (p_cached_sram_zero) else $error("sram open in cached mode");
   property p_mirror_cache_zero;
      taken && ahb_req.sel_cache && !ahb_req.write && !cache_en |=> hreadyout && hrdata == 32'h0000_0000;
   endproperty
   a_mirror_cache_zero: assert property (p_mirror_cache_zero) else $error("cache read while disabled");
   property p_miss_fill;
      $fell(hreadyout) |-> !qspi_out.cs_n && qspi_out.io_oe == OE_SINGLE && qspi_out.io_out[0] == 1'b0;
   endproperty
   a_miss_fill: assert property (p_miss_fill) else $error("miss without command");
   property p_wait_fill;
      !qspi_out.cs_n |-> !hreadyout;
   endproperty
   a_wait_fill: assert property (p_wait_fill) else $error("ready during fill");
   property p_fill_bounded;
      $fell(hreadyout) |-> ##[1:1000] hreadyout;
   endproperty
   a_fill_bounded: assert property (p_fill_bounded) else $error("fill never ends");
   property p_sck_idle;
      qspi_out.cs_n |-> !qspi_out.sck && qspi_out.io_oe == OE_NONE;
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("flash lines active while idle");
endmodule : xip_cache_sva
bind xip_flash_read_cache xip_cache_sva #(.SCK_HALF_CYCLES(SCK_HALF_CYCLES)) chk (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .cache_en(cache_en), .ahb_req(ahb_req), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .qspi_out(qspi_out), .qspi_io_in(qspi_io_in));
`default_nettype wire

// >>> tb/qspi_flash_model.sv
// Behavioural quad serial flash answering the quad output read
`timescale 1ns/1ps
`default_nettype none
module qspi_flash_model (
   // Flash pins
   input wire xip_cache_pkg::qspi_out_type qspi_out,
   output logic [3:0] qspi_io_in
);
   import xip_cache_pkg::*;
   int cnt;
   int n;
   logic [31:0] sh;
   logic [7:0] b;
   initial qspi_io_in = 4'h5;
   always @(negedge qspi_out.cs_n) cnt = 0;
   // Released lines show the inverse of the last value
   always @(posedge qspi_out.cs_n) qspi_io_in <= #2 ~qspi_io_in;
   always @(posedge qspi_out.sck) begin
      if (!qspi_out.cs_n) begin
         if (cnt < CMD_ADDR_BITS) sh = {sh[30:0], qspi_out.io_out[0]};
         cnt++;
      end
   end
   // Nibble changes after each fall, high nibble first
   always @(negedge qspi_out.sck) begin
      if (!qspi_out.cs_n && cnt >= 40 && cnt < 72) begin
         n = cnt - 40;
         // Content depends on the tag bits too, so a hit served from the wrong way shows up
         b = (sh[7:0] + sh[15:8] + 8'(n / 2)) ^ 8'h5A;
         b = (sh[31:24] == CMD_QUAD_READ) ? b : ~b;
         qspi_io_in <= #2 (n % 2) ? b[3:0] : b[7:4];
      end
   end
endmodule : qspi_flash_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the flash read cache
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
   import xip_cache_pkg::*;
   logic clk_sys;
   logic sys_rst;
   logic cache_en;
   ahb_req_type ahb_req;
   logic [31:0] hwdata;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   qspi_out_type qspi_out;
   logic [3:0] qspi_io_in;
   int fail_count;
   int tests_run;
   logic [31:0] seed;
   logic [31:0] sram [int];
   logic [31:0] rd;
   logic [31:0] d;
   int w;
   assign hready = hreadyout;
   xip_flash_read_cache #(.SCK_HALF_CYCLES(2)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .cache_en(cache_en),
      .ahb_req(ahb_req), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .qspi_out(qspi_out), .qspi_io_in(qspi_io_in));
   qspi_flash_model flash (.qspi_out(qspi_out), .qspi_io_in(qspi_io_in));
   //////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Flash byte content: line base plus address bits 15:8 plus offset, scrambled
   function automatic logic [31:0] fword(input logic [31:0] a);
      logic [7:0] l;
      l = {a[7:4], 4'h0} + a[15:8];
      return {l + 8'({a[3:2], 2'd3}) ^ 8'h5A, l + 8'({a[3:2], 2'd2}) ^ 8'h5A,
         l + 8'({a[3:2], 2'd1}) ^ 8'h5A, l + 8'({a[3:2], 2'd0}) ^ 8'h5A};
   endfunction : fword
   task automatic bus(input logic wr, input logic sc, input logic [31:0] a, input logic [2:0] sz,
      input logic [31:0] wd, output logic [31:0] r, output int nw);
      @(negedge clk_sys);
      ahb_req = '{sel_cache: sc, sel_sram: !sc, addr: a, trans: 2'b10, write: wr, size: sz};
      @(negedge clk_sys);
      ahb_req = '0;
      hwdata = wd;
      nw = 0;
      while (hreadyout !== 1'b1 && nw < 2000) begin
         @(negedge clk_sys);
         nw++;
      end
      if (nw >= 2000) fail_count++;
      r = hrdata;
   endtask : bus
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   //////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      #500000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      sys_rst = 1;
      cache_en = 0;
      ahb_req = '0;
      hwdata = '0;
      seed = 32'd53024;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 0;
      // Mirrored: array behaves as plain SRAM, byte lanes too
      for (int i = 0; i < 6; i++) begin
         d = rnd();
         bus(1, 0, 32'h0012_C000 + i * 4, 3'h2, d, rd, w);
         sram[i] = d;
      end
      bus(1, 0, 32'h0012_C001, SIZE_BYTE, 32'hA7A7_A7A7, rd, w);
      sram[0][15:8] = 8'hA7;
      d = rnd();
      bus(1, 0, 32'h0012_C00A, SIZE_HALF, d, rd, w);
      sram[2][31:16] = d[31:16];
      for (int i = 0; i < 6; i++) begin
         bus(0, 0, 32'h0012_C000 + i * 4, 3'h2, 0, rd, w);
         `CHK(rd, sram[i])
         `CHK(w, 0)
      end
      bus(0, 1, 32'h0080_0040, 3'h2, 0, rd, w);
      `CHK(rd, 32'h0000_0000)
      $display("test mirrored done");
      // Cached: five tags in one set, four must stay resident
      @(negedge clk_sys);
      cache_en = 1;
      bus(0, 0, 32'h0012_C000, 3'h2, 0, rd, w);
      `CHK(rd, 32'h0000_0000)
      for (int k = 0; k < 4; k++) begin
         d = 32'h0080_0030 + k * 32'h1000 + ((rnd() & 32'h3) << 2);
         bus(0, 1, d, 3'h2, 0, rd, w);
         `CHK(rd, fword(d))
         `CHK(w > 50, 1'b1)
      end
      for (int k = 0; k < 4; k++) begin
         d = 32'h0080_0030 + k * 32'h1000 + ((rnd() & 32'h3) << 2);
         bus(0, 1, d, 3'h2, 0, rd, w);
         `CHK(rd, fword(d))
         `CHK(w, 0)
      end
      bus(0, 1, 32'h0080_4034, 3'h2, 0, rd, w);
      `CHK(rd, fword(32'h0080_4034))
      bus(1, 1, 32'h0080_4038, 3'h2, 32'hFFFF_FFFF, rd, w);
      `CHK(w, 0)
      bus(0, 1, 32'h0080_4038, 3'h2, 0, rd, w);
      `CHK(rd, fword(32'h0080_4038))
      `CHK(w, 0)
      $display("test cached done");
      // Disable then re-enable: cold again
      @(negedge clk_sys);
      cache_en = 0;
      bus(0, 1, 32'h0080_4034, 3'h2, 0, rd, w);
      `CHK(rd, 32'h0000_0000)
      @(negedge clk_sys);
      cache_en = 1;
      bus(0, 1, 32'h0080_4034, 3'h2, 0, rd, w);
      `CHK(rd, fword(32'h0080_4034))
      `CHK(w > 50, 1'b1)
      $display("test reenable done");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
